// ### bench/pfc_core_sva.sv
// port checker for pfc_core
`default_nettype none
module pfc_core_sva #(
    parameter int PAUSE_W = 9
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic line_valid,
    input wire pfc_pkg::pfc_beat_t line_beat,
    input wire logic local_fault_indication,
    input wire logic user_packet_bus_valid,
    input wire pfc_pkg::pfc_beat_t user_packet_bus_beat,
    input wire logic [PAUSE_W-1:0] rx_pause_req,
    input wire logic [PAUSE_W-1:0] rx_pause_ack,
    input wire logic tx_pause_global_req,
    input wire logic tx_pause_ready,
    input wire logic tx_pause_valid,
    input wire pfc_pkg::pfc_hdr_t tx_pause_hdr,
    input wire logic tx_pause_is_prio
);
    // ----------
    // properties
    // ----------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_tx_req;
        tx_pause_global_req && !tx_pause_valid ##1 !tx_pause_valid;
    endsequence
    property p_fwd_cause;
        user_packet_bus_valid |-> $past(line_valid) || $past(local_fault_indication);
    endproperty
    a_fwd_cause: assert property (p_fwd_cause) else $error("beat out without cause");
    property p_cut;
        user_packet_bus_valid && !$past(line_valid) |->
            user_packet_bus_beat.eop && user_packet_bus_beat.err && user_packet_bus_beat.data == 128'h0;
    endproperty
    a_cut: assert property (p_cut) else $error("cut beat malformed");
    property p_copy;
        user_packet_bus_valid && !$past(local_fault_indication) |-> user_packet_bus_beat == $past(line_beat);
    endproperty
    a_copy: assert property (p_copy) else $error("beat not copied");
    property p_pause_g;
        $rose(rx_pause_req[pfc_pkg::PAUSE_G]) |-> $past(line_valid && line_beat.sop);
    endproperty
    a_pause_g: assert property (p_pause_g) else $error("global pause without frame");
    property p_pause_p;
        $rose(|rx_pause_req[7:0]) |-> rx_pause_req[7:0] == 8'hFF && $past(line_valid && line_beat.sop);
    endproperty
    a_pause_p: assert property (p_pause_p) else $error("priority pause wrong");
    property p_ack;
        rx_pause_req[8] && rx_pause_ack[8] |=> !rx_pause_req[8] || $past(line_valid && line_beat.sop);
    endproperty
    a_ack: assert property (p_ack) else $error("pause kept after ack");
    property p_tx_hold;
        tx_pause_valid && !tx_pause_ready |=> tx_pause_valid && $stable(tx_pause_hdr) && $stable(tx_pause_is_prio);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("pause header not held");
    property p_tx_lat;
        s_tx_req |=> tx_pause_valid && !tx_pause_is_prio;
    endproperty
    a_tx_lat: assert property (p_tx_lat) else $error("global pause header late");
endmodule
bind pfc_core pfc_core_sva #(.PAUSE_W(PAUSE_W)) pfc_core_sva_inst (
    .pclk, .presetn, .line_valid, .line_beat, .local_fault_indication, .user_packet_bus_valid,
    .user_packet_bus_beat, .rx_pause_req, .rx_pause_ack, .tx_pause_global_req, .tx_pause_ready,
    .tx_pause_valid, .tx_pause_hdr, .tx_pause_is_prio
);
`default_nettype wire

// ### bench/pfc_core_tb.sv
// self-checking bench for pfc_core
`default_nettype none
module pfc_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [47:0] MC = 48'h0180_C200_0001;
    localparam logic [47:0] UC = 48'h1122_3344_5566;
    localparam logic [127:0] NF = {48'h2, 48'h3, 32'h0800_0000};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic line_valid, lfc, sb, greq, preq, slow, uvalid, tvalid, tprio, tready;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0] req, ack;
    logic [127:0] fr [6];
    logic [2:0] ex [6];
    logic [128:0] h;
    pfc_pkg::pfc_beat_t lbeat, ubeat;
    pfc_pkg::pfc_hdr_t thdr;
    int n_errors, checked, nb, ne, ng, np, eg, ep, eb;
    pfc_core #(.PAUSE_W(9)) pfc_core_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .line_valid, .line_beat(lbeat), .local_fault_indication(lfc), .line_start_block(sb),
        .user_packet_bus_valid(uvalid), .user_packet_bus_beat(ubeat), .rx_pause_req(req),
        .rx_pause_ack(ack), .tx_pause_global_req(greq), .tx_pause_prio_req(preq),
        .tx_pause_ready(tready), .tx_pause_valid(tvalid), .tx_pause_hdr(thdr), .tx_pause_is_prio(tprio)
    );
    pfc_user_model pfc_user_model_inst (
        .pclk, .presetn, .slow, .user_packet_bus_valid(uvalid), .user_packet_bus_beat(ubeat),
        .rx_pause_req(req), .rx_pause_ack(ack), .tx_pause_valid(tvalid), .tx_pause_hdr(thdr),
        .tx_pause_is_prio(tprio), .tx_pause_ready(tready), .n_beats(nb), .n_err(ne), .n_g(ng), .n_p(np)
    );
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // -----
    // tasks
    // -----
    task automatic conclude();
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [128:0] got, input logic [128:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_errors++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic frame(input logic [127:0] hd, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            line_valid <= 1'b1;
            lbeat <= '{i == 0, i == n - 1, 1'b0, i == 0 ? hd : 128'(i)};
        end
        @(posedge pclk);
        line_valid <= 1'b0;
    endtask
    task automatic txreq(input logic g, input logic p);
        @(posedge pclk);
        greq <= g;
        preq <= p;
        @(posedge pclk);
        greq <= 1'b0;
        preq <= 1'b0;
        cyc(20);
    endtask
    // --------
    // sequence
    // --------
    initial begin
        {psel, penable, pwrite, line_valid, lfc, sb, greq, preq, slow} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        lbeat = '0;
        {n_errors, checked, eg, ep, eb} = '0;
        fr = '{{MC, 48'h0, 32'h8808_0001}, {UC, 48'h0, 32'h8808_0001}, {MC, 48'h0, 32'h8808_0101},
            {48'hBB, 48'h0, 32'h8808_0001}, {MC, 48'h0, 32'h8808_0002}, {MC, 48'h0, 32'h8809_0001}};
        ex = '{3'h1, 3'h1, 3'h2, 3'h0, 3'h0, 3'h4};
        presetn = 1'b0;
        cyc(16);
        presetn <= 1'b1;
        for (int i = 0; i < 23; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            chk(rd, i == 1 ? 32'h1 : pfc_pkg::RST[i]);
        end
        apb(1'b0, 8'h5C, 32'h0);
        chk({er, rd}, 33'h1_0000_0000);
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0000_FFFF);
        apb(1'b1, 8'h0C, 32'h0000_1122);
        apb(1'b1, 8'h08, 32'h3344_5566);
        frame(fr[0], 2);
        cyc(5);
        chk(req[8], 1'b1);
        cyc(15);
        chk(req[8], 1'b0);
        eg = 1;
        for (int i = 0; i < 6; i++) begin
            frame(fr[i], 2);
            cyc(20);
            eg += ex[i][0];
            ep += ex[i][1];
            eb += 2 * ex[i][2];
            chk(ng, eg);
            chk(np, ep);
            chk(nb, eb);
        end
        apb(1'b1, 8'h00, 32'h6);
        frame(fr[0], 2);
        cyc(20);
        eg++;
        eb += 2;
        chk(nb, eb);
        apb(1'b1, 8'h18, 32'hAA);
        apb(1'b1, 8'h00, 32'hA);
        frame(fr[0], 2);
        cyc(20);
        chk(ng, eg);
        frame({MC, 48'hAA, 32'h8808_0001}, 2);
        cyc(20);
        eg++;
        chk(ng, eg);
        apb(1'b1, 8'h00, 32'h0);
        frame(fr[0], 2);
        cyc(3);
        eg++;
        chk(req[8], 1'b0);
        chk(ng, eg);
        lfc <= 1'b1;
        frame(NF, 3);
        lfc <= 1'b0;
        cyc(3);
        eb += 3;
        chk(nb, eb);
        chk(ne, 0);
        apb(1'b1, 8'h28, 32'h8809_8808);
        frame(fr[5], 2);
        cyc(3);
        chk(nb, eb);
        apb(1'b1, 8'h00, 32'h3);
        @(posedge pclk);
        line_valid <= 1'b1;
        lbeat <= '{1'b1, 1'b0, 1'b0, NF};
        @(posedge pclk);
        lbeat <= '{1'b0, 1'b0, 1'b0, 128'h5};
        @(posedge pclk);
        lfc <= 1'b1;
        line_valid <= 1'b0;
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[2:0], 3'h2);
        lfc <= 1'b0;
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[2:0], 3'h4);
        eb += 3;
        chk(nb, eb);
        chk(ne, 1);
        frame(NF, 2);
        cyc(3);
        chk(nb, eb);
        sb <= 1'b1;
        cyc(1);
        sb <= 1'b0;
        cyc(2);
        frame(NF, 2);
        cyc(3);
        eb += 2;
        chk(nb, eb);
        txreq(1'b1, 1'b0);
        h = pfc_user_model_inst.hq.pop_front();
        chk(h, {1'b0, MC, 48'h0, 32'h8808_0001});
        txreq(1'b0, 1'b1);
        h = pfc_user_model_inst.hq.pop_front();
        chk(h, {1'b1, MC, 48'h0, 32'h8808_0101});
        apb(1'b1, 8'h34, 32'h0777);
        apb(1'b1, 8'h38, 32'h0002);
        apb(1'b1, 8'h44, 32'h8808_0009);
        apb(1'b1, 8'h50, 32'h55);
        slow <= 1'b1;
        txreq(1'b1, 1'b1);
        chk(pfc_user_model_inst.hq.size(), 2);
        h = pfc_user_model_inst.hq.pop_front();
        chk(h, {1'b0, 48'h0002_0000_0777, 48'h0, 32'h8808_0009});
        h = pfc_user_model_inst.hq.pop_front();
        chk(h, {1'b1, MC, 48'h55, 32'h8808_0101});
        conclude();
    end
endmodule
`default_nettype wire

// ### bench/pfc_user_model.sv
// user side model: acks pauses, takes pause headers, counts beats
`default_nettype none
module pfc_user_model #(
    parameter int ACK_DLY = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic user_packet_bus_valid,
    input wire pfc_pkg::pfc_beat_t user_packet_bus_beat,
    input wire logic [8:0] rx_pause_req,
    output logic [8:0] rx_pause_ack,
    input wire logic tx_pause_valid,
    input wire pfc_pkg::pfc_hdr_t tx_pause_hdr,
    input wire logic tx_pause_is_prio,
    output logic tx_pause_ready,
    output var int n_beats,
    output var int n_err,
    output var int n_g,
    output var int n_p
);
    int gcnt, pcnt;
    logic [1:0] cyc;
    logic [8:0] req_q;
    logic [128:0] hq [$];
    assign rx_pause_ack = {rx_pause_req[8] && gcnt == ACK_DLY, rx_pause_req[7:0] & {8{pcnt == ACK_DLY}}};
    assign tx_pause_ready = !slow || cyc == 2'h3;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {n_beats, n_err, n_g, n_p, gcnt, pcnt} <= '0;
            cyc <= 2'h0;
            req_q <= 9'h000;
        end else begin
            cyc <= cyc + 2'h1;
            req_q <= rx_pause_req;
            gcnt <= (rx_pause_req[8] && !rx_pause_ack[8]) ? gcnt + 1 : 0;
            pcnt <= (rx_pause_req[0] && !rx_pause_ack[0]) ? pcnt + 1 : 0;
            if (user_packet_bus_valid) n_beats <= n_beats + 1;
            if (user_packet_bus_valid && user_packet_bus_beat.err) n_err <= n_err + 1;
            if (rx_pause_req[8] && !req_q[8]) n_g <= n_g + 1;
            if (rx_pause_req[0] && !req_q[0]) n_p <= n_p + 1;
            if (tx_pause_valid && tx_pause_ready) hq.push_back({tx_pause_is_prio, tx_pause_hdr});
        end
    end
endmodule
`default_nettype wire

// ### hw/pfc_core.sv
// pause frame classification, fault gating and register file
//
// Chosen here: the APB register port and the address map.
`default_nettype none
module pfc_core #(
    parameter int PAUSE_W = 9
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic line_valid,
    input wire pfc_pkg::pfc_beat_t line_beat,
    input wire logic local_fault_indication,
    input wire logic line_start_block,
    output logic user_packet_bus_valid,
    output pfc_pkg::pfc_beat_t user_packet_bus_beat,
    output logic [PAUSE_W-1:0] rx_pause_req,
    input wire logic [PAUSE_W-1:0] rx_pause_ack,
    input wire logic tx_pause_global_req,
    input wire logic tx_pause_prio_req,
    input wire logic tx_pause_ready,
    output logic tx_pause_valid,
    output pfc_pkg::pfc_hdr_t tx_pause_hdr,
    output logic tx_pause_is_prio
);

    // ----------------------------------------
    // parameter check
    // ----------------------------------------
    if (PAUSE_W != pfc_pkg::PAUSE_N) begin : g_bad_w
        $error("pause width must be nine");
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [31:0] cfg_reg [pfc_pkg::NREG];
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic [pfc_pkg::IDX_W-1:0] idx;
    logic mapped;
    logic setup;
    logic wr_en;

    assign idx = paddr[6:2];
    assign mapped = (paddr[1:0] == 2'h0) && !paddr[7]
        && (idx < pfc_pkg::IDX_W'(pfc_pkg::NREG));
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && mapped
        && (idx != pfc_pkg::IDX_STATUS);
    assign rd_word = !mapped ? 32'h0000_0000
        : (idx == pfc_pkg::IDX_STATUS) ? status_word
        : cfg_reg[idx];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < pfc_pkg::NREG; i++) begin
                cfg_reg[i] <= pfc_pkg::RST[i];
            end
        end else if (wr_en) begin
            cfg_reg[idx] <= pwdata & pfc_pkg::MASK[idx];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr_reg <= !mapped;
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;
    assign pready = 1'b1;

    // ----------------------------------------
    // configuration fields
    // ----------------------------------------
    logic rx_local_fault_process_en;
    logic rx_check_ack;
    logic rx_forward_control;
    logic rx_source_check_en;
    logic [47:0] rx_pause_dest_unicast;
    logic [47:0] rx_pause_dest_multicast;
    logic [47:0] rx_pause_source_addr;
    logic [15:0] rx_global_ctrl_opcode_lo;
    logic [15:0] rx_global_ctrl_opcode_hi;
    logic [15:0] rx_global_ctrl_ethertype;
    logic [15:0] rx_prio_ctrl_ethertype;
    logic [15:0] rx_prio_ctrl_opcode_lo;
    logic [15:0] rx_prio_ctrl_opcode_hi;
    logic [15:0] rx_global_pause_ethertype;
    logic [15:0] rx_global_pause_opcode;
    logic [15:0] rx_prio_pause_ethertype;
    logic [15:0] rx_prio_pause_opcode;
    pfc_pkg::pfc_hdr_t tx_gpp_hdr;
    pfc_pkg::pfc_hdr_t tx_ppp_hdr;

    assign rx_local_fault_process_en =
        cfg_reg[pfc_pkg::IDX_CTRL][pfc_pkg::CTRL_LF];
    assign rx_check_ack = cfg_reg[pfc_pkg::IDX_CTRL][pfc_pkg::CTRL_ACK];
    assign rx_forward_control = cfg_reg[pfc_pkg::IDX_CTRL][pfc_pkg::CTRL_FWD];
    assign rx_source_check_en = cfg_reg[pfc_pkg::IDX_CTRL][pfc_pkg::CTRL_SAC];
    assign rx_pause_dest_unicast = {cfg_reg[pfc_pkg::IDX_RX_UCAST_HI][15:0],
        cfg_reg[pfc_pkg::IDX_RX_UCAST_LO]};
    assign rx_pause_dest_multicast = {cfg_reg[pfc_pkg::IDX_RX_MCAST_HI][15:0],
        cfg_reg[pfc_pkg::IDX_RX_MCAST_LO]};
    assign rx_pause_source_addr = {cfg_reg[pfc_pkg::IDX_RX_SA_HI][15:0],
        cfg_reg[pfc_pkg::IDX_RX_SA_LO]};
    assign rx_global_ctrl_opcode_lo = cfg_reg[pfc_pkg::IDX_RX_GCP_OP][15:0];
    assign rx_global_ctrl_opcode_hi = cfg_reg[pfc_pkg::IDX_RX_GCP_OP][31:16];
    assign rx_prio_ctrl_opcode_lo = cfg_reg[pfc_pkg::IDX_RX_PCP_OP][15:0];
    assign rx_prio_ctrl_opcode_hi = cfg_reg[pfc_pkg::IDX_RX_PCP_OP][31:16];
    assign rx_global_ctrl_ethertype = cfg_reg[pfc_pkg::IDX_RX_CTL_ET][15:0];
    assign rx_prio_ctrl_ethertype = cfg_reg[pfc_pkg::IDX_RX_CTL_ET][31:16];
    assign rx_global_pause_ethertype = cfg_reg[pfc_pkg::IDX_RX_GPP][31:16];
    assign rx_global_pause_opcode = cfg_reg[pfc_pkg::IDX_RX_GPP][15:0];
    assign rx_prio_pause_ethertype = cfg_reg[pfc_pkg::IDX_RX_PPP][31:16];
    assign rx_prio_pause_opcode = cfg_reg[pfc_pkg::IDX_RX_PPP][15:0];

    assign tx_gpp_hdr.da = {cfg_reg[pfc_pkg::IDX_TX_GPP_DA_HI][15:0],
        cfg_reg[pfc_pkg::IDX_TX_GPP_DA_LO]};
    assign tx_gpp_hdr.sa = {cfg_reg[pfc_pkg::IDX_TX_GPP_SA_HI][15:0],
        cfg_reg[pfc_pkg::IDX_TX_GPP_SA_LO]};
    assign tx_gpp_hdr.etype = cfg_reg[pfc_pkg::IDX_TX_GPP][31:16];
    assign tx_gpp_hdr.opcode = cfg_reg[pfc_pkg::IDX_TX_GPP][15:0];
    assign tx_ppp_hdr.da = {cfg_reg[pfc_pkg::IDX_TX_PPP_DA_HI][15:0],
        cfg_reg[pfc_pkg::IDX_TX_PPP_DA_LO]};
    assign tx_ppp_hdr.sa = {cfg_reg[pfc_pkg::IDX_TX_PPP_SA_HI][15:0],
        cfg_reg[pfc_pkg::IDX_TX_PPP_SA_LO]};
    assign tx_ppp_hdr.etype = cfg_reg[pfc_pkg::IDX_TX_PPP][31:16];
    assign tx_ppp_hdr.opcode = cfg_reg[pfc_pkg::IDX_TX_PPP][15:0];

    // ----------------------------------------
    // header classification
    // ----------------------------------------
    pfc_pkg::pfc_hdr_t hdr;
    logic da_hit;
    logic sa_hit;
    logic is_gpp;
    logic is_ppp;
    logic is_gcp;
    logic is_pcp;
    logic is_ctrl;

    assign hdr = line_beat.data;
    assign da_hit = (hdr.da == rx_pause_dest_unicast)
        || (hdr.da == rx_pause_dest_multicast);
    assign sa_hit = !rx_source_check_en
        || (hdr.sa == rx_pause_source_addr);
    assign is_gpp = da_hit && sa_hit
        && (hdr.etype == rx_global_pause_ethertype)
        && (hdr.opcode == rx_global_pause_opcode);
    assign is_ppp = da_hit && sa_hit
        && (hdr.etype == rx_prio_pause_ethertype)
        && (hdr.opcode == rx_prio_pause_opcode);
    assign is_gcp = (hdr.etype == rx_global_ctrl_ethertype)
        && (hdr.opcode >= rx_global_ctrl_opcode_lo)
        && (hdr.opcode <= rx_global_ctrl_opcode_hi);
    assign is_pcp = (hdr.etype == rx_prio_ctrl_ethertype)
        && (hdr.opcode >= rx_prio_ctrl_opcode_lo)
        && (hdr.opcode <= rx_prio_ctrl_opcode_hi);
    assign is_ctrl = is_gcp || is_pcp || is_gpp || is_ppp;

    // ----------------------------------------
    // local fault state machine
    // ----------------------------------------
    pfc_pkg::pfc_state_t st_reg;
    pfc_pkg::pfc_state_t st_next;
    logic fault_now;

    assign fault_now = rx_local_fault_process_en
        && local_fault_indication;

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            pfc_pkg::ST_RUN: begin
                if (fault_now) begin
                    st_next = pfc_pkg::ST_FAULT;
                end
            end
            pfc_pkg::ST_FAULT: begin
                if (!fault_now) begin
                    st_next = pfc_pkg::ST_WAIT;
                end
            end
            pfc_pkg::ST_WAIT: begin
                if (fault_now) begin
                    st_next = pfc_pkg::ST_FAULT;
                end else if (line_start_block) begin
                    st_next = pfc_pkg::ST_RUN;
                end
            end
            default: begin
                st_next = pfc_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= pfc_pkg::ST_RUN;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // packet path
    // ----------------------------------------
    logic in_pkt_reg;
    logic in_pkt_next;
    logic drop_reg;
    logic drop_next;
    logic take;
    logic start;
    logic cont;
    logic drop_now;
    logic cut;
    logic out_valid_next;
    pfc_pkg::pfc_beat_t cut_beat;

    assign take = line_valid && (st_reg == pfc_pkg::ST_RUN)
        && !fault_now;
    assign start = take && line_beat.sop;
    assign cont = take && !line_beat.sop && in_pkt_reg;
    assign drop_now = start ? (is_ctrl && !rx_forward_control)
        : drop_reg;
    assign cut = in_pkt_reg && (st_reg == pfc_pkg::ST_RUN)
        && fault_now;
    assign cut_beat = '{sop: 1'b0, eop: 1'b1, err: 1'b1,
        data: 128'h0};
    assign out_valid_next = cut ? !drop_reg
        : ((start || cont) && !drop_now);
    assign in_pkt_next = cut ? 1'b0
        : (start || cont) ? !line_beat.eop
        : in_pkt_reg;
    assign drop_next = start ? drop_now : drop_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_pkt_reg <= 1'b0;
            drop_reg <= 1'b0;
            user_packet_bus_valid <= 1'b0;
            user_packet_bus_beat <= '0;
        end else begin
            in_pkt_reg <= in_pkt_next;
            drop_reg <= drop_next;
            user_packet_bus_valid <= out_valid_next;
            if (out_valid_next) begin
                user_packet_bus_beat <= cut ? cut_beat : line_beat;
            end
        end
    end

    // ----------------------------------------
    // received pause requests
    // ----------------------------------------
    logic [PAUSE_W-1:0] pend_reg;
    logic [PAUSE_W-1:0] pend_next;
    logic [PAUSE_W-1:0] pend_set;
    logic [PAUSE_W-1:0] pend_clr;

    assign pend_set = {start && is_gpp,
        {(PAUSE_W-1){start && is_ppp}}};
    assign pend_clr = rx_check_ack ? rx_pause_ack
        : {PAUSE_W{1'b1}};
    assign pend_next = (pend_reg & ~pend_clr) | pend_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= pend_next;
        end
    end

    assign rx_pause_req = pend_reg;

    // ----------------------------------------
    // status word
    // ----------------------------------------
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[pfc_pkg::STS_STATE +: 3] = st_reg;
        status_word[pfc_pkg::STS_PEND +: PAUSE_W] = pend_reg;
        status_word[pfc_pkg::STS_INPKT] = in_pkt_reg;
    end

    // ----------------------------------------
    // transmit pause composer
    // ----------------------------------------
    pfc_tx_pause u_tx_pause (
        .pclk(pclk),
        .presetn(presetn),
        .global_req(tx_pause_global_req),
        .prio_req(tx_pause_prio_req),
        .gpp_hdr(tx_gpp_hdr),
        .ppp_hdr(tx_ppp_hdr),
        .hdr_ready(tx_pause_ready),
        .hdr_valid(tx_pause_valid),
        .hdr(tx_pause_hdr),
        .hdr_is_prio(tx_pause_is_prio)
    );

endmodule
`default_nettype wire

// ### hw/pfc_pkg.sv
// pause frame and fault control: shared constants and types
// Functional notes
// - lf enabled: receiver acts on local fault
// - lf disabled by default: fault codes ignored
// - fault stops receive, cuts packet with error
// - after fault, resume only at start block
// - unicast pause destination, default zero
// - multicast pause destination, default 0180C2000001
// - pause source address compare, default zero
// - global control opcode range, full default
// - global control ethertype, default 8808
// - priority control ethertype and opcode range
// - global pause ethertype 8808, opcode 0001
// - priority pause ethertype 8808, opcode 0101
// - ack check holds pause until acknowledged
// - control frames forwarded or dropped
// - tx global pause addresses configurable
// - tx global pause ethertype and opcode
// - tx priority pause addresses configurable
// - tx priority pause ethertype and opcode
`default_nettype none
package pfc_pkg;
    localparam int NREG = 23;
    localparam int IDX_W = 5;
    localparam logic [IDX_W-1:0] IDX_CTRL = 5'h00;
    localparam logic [IDX_W-1:0] IDX_STATUS = 5'h01;
    localparam logic [IDX_W-1:0] IDX_RX_UCAST_LO = 5'h02;
    localparam logic [IDX_W-1:0] IDX_RX_UCAST_HI = 5'h03;
    localparam logic [IDX_W-1:0] IDX_RX_MCAST_LO = 5'h04;
    localparam logic [IDX_W-1:0] IDX_RX_MCAST_HI = 5'h05;
    localparam logic [IDX_W-1:0] IDX_RX_SA_LO = 5'h06;
    localparam logic [IDX_W-1:0] IDX_RX_SA_HI = 5'h07;
    localparam logic [IDX_W-1:0] IDX_RX_GCP_OP = 5'h08;
    localparam logic [IDX_W-1:0] IDX_RX_PCP_OP = 5'h09;
    localparam logic [IDX_W-1:0] IDX_RX_CTL_ET = 5'h0A;
    localparam logic [IDX_W-1:0] IDX_RX_GPP = 5'h0B;
    localparam logic [IDX_W-1:0] IDX_RX_PPP = 5'h0C;
    localparam logic [IDX_W-1:0] IDX_TX_GPP_DA_LO = 5'h0D;
    localparam logic [IDX_W-1:0] IDX_TX_GPP_DA_HI = 5'h0E;
    localparam logic [IDX_W-1:0] IDX_TX_GPP_SA_LO = 5'h0F;
    localparam logic [IDX_W-1:0] IDX_TX_GPP_SA_HI = 5'h10;
    localparam logic [IDX_W-1:0] IDX_TX_GPP = 5'h11;
    localparam logic [IDX_W-1:0] IDX_TX_PPP_DA_LO = 5'h12;
    localparam logic [IDX_W-1:0] IDX_TX_PPP_DA_HI = 5'h13;
    localparam logic [IDX_W-1:0] IDX_TX_PPP_SA_LO = 5'h14;
    localparam logic [IDX_W-1:0] IDX_TX_PPP_SA_HI = 5'h15;
    localparam logic [IDX_W-1:0] IDX_TX_PPP = 5'h16;
    // control word bits
    localparam int CTRL_LF = 0;
    localparam int CTRL_ACK = 1;
    localparam int CTRL_FWD = 2;
    localparam int CTRL_SAC = 3;
    // status word fields
    localparam int STS_STATE = 0;
    localparam int STS_PEND = 4;
    localparam int STS_INPKT = 16;
    localparam int PAUSE_N = 9;
    localparam int PAUSE_G = 8;
    localparam logic [31:0] RST [NREG] = '{
        32'h0000_0002, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'hC200_0001, 32'h0000_0180, 32'h0000_0000, 32'h0000_0000,
        32'hFFFF_0000, 32'hFFFF_0000, 32'h8808_8808, 32'h8808_0001,
        32'h8808_0101, 32'hC200_0001, 32'h0000_0180, 32'h0000_0000,
        32'h0000_0000, 32'h8808_0001, 32'hC200_0001, 32'h0000_0180,
        32'h0000_0000, 32'h0000_0000, 32'h8808_0101};
    localparam logic [31:0] MASK [NREG] = '{
        32'h0000_000F, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_FFFF,
        32'hFFFF_FFFF, 32'h0000_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF, 32'hFFFF_FFFF,
        32'h0000_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_FFFF,
        32'hFFFF_FFFF, 32'h0000_FFFF, 32'hFFFF_FFFF};
    typedef struct packed {
        logic [47:0] da;
        logic [47:0] sa;
        logic [15:0] etype;
        logic [15:0] opcode;
    } pfc_hdr_t;
    typedef struct packed {
        logic sop;
        logic eop;
        logic err;
        logic [127:0] data;
    } pfc_beat_t;
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_FAULT = 3'b010,
        ST_WAIT = 3'b100
    } pfc_state_t;
endpackage
`default_nettype wire

// ### hw/pfc_tx_pause.sv
// transmit pause header composer
`default_nettype none
module pfc_tx_pause (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic global_req,
    input wire logic prio_req,
    input wire pfc_pkg::pfc_hdr_t gpp_hdr,
    input wire pfc_pkg::pfc_hdr_t ppp_hdr,
    input wire logic hdr_ready,
    output logic hdr_valid,
    output pfc_pkg::pfc_hdr_t hdr,
    output logic hdr_is_prio
);
    logic gpend_reg;
    logic ppend_reg;
    logic gpend_next;
    logic ppend_next;
    logic load;
    logic valid_next;
    assign load = (!hdr_valid || hdr_ready) && (gpend_reg || ppend_reg);
    // request set wins over consume
    assign gpend_next = global_req || (gpend_reg && !(load && gpend_reg));
    assign ppend_next = prio_req || (ppend_reg && !(load && !gpend_reg));
    assign valid_next = load || (hdr_valid && !hdr_ready);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpend_reg <= 1'b0;
            ppend_reg <= 1'b0;
            hdr_valid <= 1'b0;
            hdr <= '0;
            hdr_is_prio <= 1'b0;
        end else begin
            gpend_reg <= gpend_next;
            ppend_reg <= ppend_next;
            hdr_valid <= valid_next;
            if (load) begin
                hdr <= gpend_reg ? gpp_hdr : ppp_hdr;
                hdr_is_prio <= !gpend_reg;
            end
        end
    end
endmodule
`default_nettype wire
